/* File: rtl/bcc_map.vh */
// Register map, field positions, codes and reset values of the capture/compare unit
`ifndef BCC_MAP_VH
`define BCC_MAP_VH

// Channel count: seven channels, 0 to 6
`define BCC_NCH 7

// Register indices on the plain register port
`define BCC_A_CTRL 8'h00
`define BCC_A_COUNT 8'h01
`define BCC_A_CCTL 8'h10
`define BCC_A_CCR 8'h20

// Timer control fields
`define BCC_F_MC 1
`define BCC_F_GRP 3
`define BCC_F_HIZ 4
`define BCC_F_CLR 5
`define BCC_F_DIR 6

// Channel control fields
`define BCC_F_EDGE 15
`define BCC_F_SRC 13
`define BCC_F_SCS 11
`define BCC_F_LVL 10
`define BCC_F_CLLD 9
`define BCC_F_OMODE 7
`define BCC_F_CAP 4
`define BCC_F_OBIT 3
`define BCC_F_COV 2
`define BCC_F_FLAG 1

// Counter modes
`define BCC_MC_STOP 2'h0
`define BCC_MC_UP 2'h1
`define BCC_MC_CONT 2'h2
`define BCC_MC_UPDN 2'h3

// Edge selector codes
`define BCC_EDGE_NONE 2'h0
`define BCC_EDGE_RISE 2'h1
`define BCC_EDGE_FALL 2'h2
`define BCC_EDGE_BOTH 2'h3

// Input source codes
`define BCC_SRC_A 2'h0
`define BCC_SRC_B 2'h1
`define BCC_SRC_GND 2'h2
`define BCC_SRC_VCC 2'h3

// Latch load events
`define BCC_LD_NOW 2'h0
`define BCC_LD_ZERO 2'h1
`define BCC_LD_ZPER 2'h2
`define BCC_LD_OLD 2'h3

// Reset values
`define BCC_CTRL_RST 16'h0000
`define BCC_CCTL_RST 16'h0000
`define BCC_WORD_RST 16'h0000

`endif

/* File: rtl/bcc_out_unit.v */
// Output unit of one capture/compare channel
`timescale 1ns/1ps
module bcc_out_unit (
  // Clock and reset
  input wire i_clk,
  input wire i_arst_n,
  // Control
  input wire [2:0] i_mode,
  input wire i_sw_bit,
  input wire i_hiz,
  // Match events
  input wire i_ch_match,
  input wire i_per_match,
  // Pin
  output reg o_out,
  output reg o_oe
);

  reg out_nxt;

  always @* begin
    out_nxt = o_out;
    case (i_mode)
      3'h0: out_nxt = i_sw_bit;
      3'h1: if (i_ch_match) out_nxt = 1'b1;
      3'h2: if (i_ch_match) out_nxt = ~o_out; else if (i_per_match) out_nxt = 1'b0;
      3'h3: if (i_ch_match) out_nxt = 1'b1; else if (i_per_match) out_nxt = 1'b0;
      3'h4: if (i_ch_match) out_nxt = ~o_out;
      3'h5: if (i_ch_match) out_nxt = 1'b0;
      3'h6: if (i_ch_match) out_nxt = ~o_out; else if (i_per_match) out_nxt = 1'b1;
      3'h7: if (i_ch_match) out_nxt = 1'b0; else if (i_per_match) out_nxt = 1'b1;
      default: out_nxt = o_out;
    endcase
  end

  // Output changes on the clock edge in every mode
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_out <= 1'b0;
      o_oe <= 1'b0;
    end else begin
      o_out <= out_nxt;
      o_oe <= ~i_hiz;
    end
  end

endmodule

/* File: rtl/bcc_top.v */
// Buffered capture/compare unit of a 16-bit timer, with its counter
//
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "bcc_map.vh"
module bcc_top (
  // Clock and reset
  input wire I_MCLK,
  input wire I_ARST_N,
  // Register port
  input wire [7:0] I_ADDR,
  input wire [15:0] I_WDATA,
  input wire I_WR,
  input wire I_RD,
  output reg [15:0] O_RDATA,
  // Capture inputs
  input wire [6:0] I_CAP_A,
  input wire [6:0] I_CAP_B,
  // High-impedance pin
  input wire I_HIZ_PIN,
  // Channel outputs
  output wire [6:0] O_OUT,
  output wire [6:0] O_OUT_OE,
  output reg [6:0] O_FLAG
);

  localparam NCH = `BCC_NCH;

  ////////////////////////////////////////////////////////////////////////////
  // Group controller of a channel
  function [2:0] ctl_of;
    input [1:0] grp;
    input [2:0] ch;
    begin
      case (grp)
        2'h1: ctl_of = (ch == 3'h0) ? 3'h0 : (ch[0] ? ch : ch - 3'h1);
        2'h2: ctl_of = (ch == 3'h0) ? 3'h0 : ((ch <= 3'h3) ? 3'h1 : 3'h4);
        2'h3: ctl_of = 3'h1;
        default: ctl_of = ch;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Timer control and counter
  reg [15:0] ctrl_r;
  reg [15:0] cnt_r;
  reg [15:0] cnt_nxt;
  reg down_r;
  reg down_nxt;
  reg step;
  reg arrived_r;
  reg [15:0] per_hold_r;
  wire [1:0] mode = ctrl_r[`BCC_F_MC -: 2];
  wire [1:0] grp = ctrl_r[`BCC_F_GRP -: 2];
  wire hiz = ctrl_r[`BCC_F_HIZ] & I_HIZ_PIN;
  wire [16*NCH-1:0] latch_v;
  wire [15:0] period = latch_v[15:0];
  wire ctrl_wr = I_WR && (I_ADDR == `BCC_A_CTRL);
  wire cnt_wr = I_WR && (I_ADDR == `BCC_A_COUNT);
  wire clr = ctrl_wr && I_WDATA[`BCC_F_CLR];

  always @* begin
    cnt_nxt = cnt_r;
    down_nxt = down_r;
    step = 1'b0;
    case (mode)
      `BCC_MC_UP: begin
        if (period != 16'h0000) begin
          step = 1'b1;
          if (cnt_r >= period) cnt_nxt = 16'h0000;
          else cnt_nxt = cnt_r + 16'h0001;
        end
      end
      `BCC_MC_CONT: begin
        step = 1'b1;
        cnt_nxt = cnt_r + 16'h0001;
      end
      `BCC_MC_UPDN: begin
        if (period != 16'h0000) begin
          step = 1'b1;
          if (!down_r) begin
            if (cnt_r >= period) begin
              down_nxt = 1'b1;
              cnt_nxt = cnt_r - 16'h0001;
            end else begin
              cnt_nxt = cnt_r + 16'h0001;
            end
          end else if (cnt_r == 16'h0000) begin
            down_nxt = 1'b0;
            cnt_nxt = 16'h0001;
          end else begin
            cnt_nxt = cnt_r - 16'h0001;
            if (cnt_r == 16'h0001) down_nxt = 1'b0;
          end
        end
      end
      default: step = 1'b0;
    endcase
  end

  always @(posedge I_MCLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      ctrl_r <= `BCC_CTRL_RST;
      cnt_r <= `BCC_WORD_RST;
      down_r <= 1'b0;
      arrived_r <= 1'b0;
      per_hold_r <= `BCC_WORD_RST;
    end else begin
      // Period in force while counting down, so a new period waits for zero
      if (!down_r) per_hold_r <= period;
      if (ctrl_wr) ctrl_r <= I_WDATA & 16'h001f;
      if (clr) begin
        cnt_r <= 16'h0000;
        down_r <= 1'b0;
        arrived_r <= 1'b0;
      end else if (cnt_wr) begin
        cnt_r <= I_WDATA;
        arrived_r <= 1'b0;
      end else begin
        cnt_r <= cnt_nxt;
        down_r <= down_nxt;
        arrived_r <= step;
      end
    end
  end

  // Events when the counter counts onto a value
  wire zero_ev = arrived_r && (cnt_r == 16'h0000);
  wire [15:0] per_now = down_r ? per_hold_r : period;
  wire per_ev = arrived_r && (cnt_r == per_now);

  ////////////////////////////////////////////////////////////////////////////
  // Latch loading and grouping
  wire [16*NCH-1:0] cctl_v;
  wire [NCH-1:0] pend_v;
  reg [NCH-1:0] load;
  reg [NCH-1:0] all_pend;
  reg [2:0] c;
  reg [1:0] cl;
  reg ev;
  integer i;
  integer j;

  always @* begin
    load = {NCH{1'b0}};
    all_pend = {NCH{1'b0}};
    c = 3'h0;
    cl = 2'h0;
    ev = 1'b0;
    for (i = 0; i < NCH; i = i + 1) begin
      c = ctl_of(grp, i[2:0]);
      all_pend[i] = 1'b1;
      for (j = 0; j < NCH; j = j + 1) begin
        if (ctl_of(grp, j[2:0]) == c && !pend_v[j]) all_pend[i] = 1'b0;
      end
      cl = cctl_v[16*c + `BCC_F_CLLD -: 2];
      case (cl)
        `BCC_LD_ZERO: ev = zero_ev;
        `BCC_LD_ZPER: ev = zero_ev || (mode == `BCC_MC_UPDN && per_ev);
        `BCC_LD_OLD: ev = arrived_r && (cnt_r == latch_v[16*i +: 16]);
        default: ev = 1'b1;
      endcase
      if (cl == `BCC_LD_NOW) load[i] = pend_v[i];
      else load[i] = all_pend[i] && ev;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channels
  wire [16*NCH-1:0] buf_v;
  wire [NCH-1:0] lvl_v;
  wire [NCH-1:0] flag_v;
  wire [NCH-1:0] cov_v;
  wire [NCH-1:0] chm_v;

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : ch
      reg [15:0] cctl_r;
      reg [15:0] buf_r;
      reg [15:0] latch_r;
      reg pend_r;
      reg prev_r;
      reg hit_d_r;
      reg unread_r;
      reg flag_r;
      reg cov_r;
      reg sel_in;
      reg hit;
      wire cw = I_WR && (I_ADDR == `BCC_A_CCTL + g);
      wire bw = I_WR && (I_ADDR == `BCC_A_CCR + g);
      wire br = I_RD && (I_ADDR == `BCC_A_CCR + g);
      wire cap = cctl_r[`BCC_F_CAP];
      wire [1:0] src = cctl_r[`BCC_F_SRC -: 2];
      wire [1:0] edg = cctl_r[`BCC_F_EDGE -: 2];
      wire cap_now = cap && (cctl_r[`BCC_F_SCS] ? hit_d_r : hit);
      wire chm = !cap && arrived_r && (cnt_r == latch_r);

      always @* begin
        case (src)
          `BCC_SRC_A: sel_in = I_CAP_A[g];
          `BCC_SRC_B: sel_in = I_CAP_B[g];
          `BCC_SRC_GND: sel_in = 1'b0;
          default: sel_in = 1'b1;
        endcase
        case (edg)
          `BCC_EDGE_RISE: hit = sel_in & ~prev_r;
          `BCC_EDGE_FALL: hit = ~sel_in & prev_r;
          `BCC_EDGE_BOTH: hit = sel_in ^ prev_r;
          default: hit = 1'b0;
        endcase
      end

      always @(posedge I_MCLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
          cctl_r <= `BCC_CCTL_RST;
          buf_r <= `BCC_WORD_RST;
          latch_r <= `BCC_WORD_RST;
          pend_r <= 1'b0;
          prev_r <= 1'b0;
          hit_d_r <= 1'b0;
          unread_r <= 1'b0;
          flag_r <= 1'b0;
          cov_r <= 1'b0;
        end else begin
          prev_r <= sel_in;
          hit_d_r <= hit;
          if (cw) cctl_r <= I_WDATA & 16'hfbf8;
          // Flag and overrun: hardware set wins over a software clear
          if (cap_now || chm) flag_r <= 1'b1;
          else if (cw) flag_r <= I_WDATA[`BCC_F_FLAG];
          if (cap_now && unread_r) cov_r <= 1'b1;
          else if (cw) cov_r <= I_WDATA[`BCC_F_COV];
          if (cap_now) unread_r <= 1'b1;
          else if (br) unread_r <= 1'b0;
          if (cap_now) buf_r <= cnt_r;
          else if (bw) buf_r <= I_WDATA;
          if (bw) pend_r <= 1'b1;
          else if (load[g]) pend_r <= 1'b0;
          if (load[g]) latch_r <= buf_r;
        end
      end

      assign cctl_v[16*g +: 16] = cctl_r;
      assign buf_v[16*g +: 16] = buf_r;
      assign latch_v[16*g +: 16] = latch_r;
      assign pend_v[g] = pend_r;
      assign lvl_v[g] = sel_in;
      assign flag_v[g] = flag_r;
      assign cov_v[g] = cov_r;
      assign chm_v[g] = chm;

      bcc_out_unit u_out (
        .i_clk(I_MCLK),
        .i_arst_n(I_ARST_N),
        .i_mode(cctl_r[`BCC_F_OMODE -: 3]),
        .i_sw_bit(cctl_r[`BCC_F_OBIT]),
        .i_hiz(hiz),
        .i_ch_match(chm_v[g]),
        .i_per_match(per_ev),
        .o_out(O_OUT[g]),
        .o_oe(O_OUT_OE[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the read strobe
  reg [15:0] rd_nxt;
  integer k;

  always @* begin
    rd_nxt = 16'h0000;
    if (I_ADDR == `BCC_A_CTRL) rd_nxt = {9'h000, down_r, 1'b0, ctrl_r[4:0]};
    if (I_ADDR == `BCC_A_COUNT) rd_nxt = cnt_r;
    for (k = 0; k < NCH; k = k + 1) begin
      if (I_ADDR == `BCC_A_CCTL + k[7:0]) begin
        rd_nxt = cctl_v[16*k +: 16];
        rd_nxt[`BCC_F_LVL] = lvl_v[k];
        rd_nxt[`BCC_F_COV] = cov_v[k];
        rd_nxt[`BCC_F_FLAG] = flag_v[k];
      end
      if (I_ADDR == `BCC_A_CCR + k[7:0]) rd_nxt = buf_v[16*k +: 16];
    end
  end

  always @(posedge I_MCLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_RDATA <= 16'h0000;
      O_FLAG <= {NCH{1'b0}};
    end else begin
      if (I_RD) O_RDATA <= rd_nxt;
      O_FLAG <= flag_v;
    end
  end

endmodule

/* File: test/bcc_chk.sv */
// Port-level assertions of the capture/compare unit
`timescale 1ns/1ps
module bcc_chk (
  // Clock and reset
  input wire I_MCLK,
  input wire I_ARST_N,
  // Register port
  input wire [7:0] I_ADDR,
  input wire [15:0] I_WDATA,
  input wire I_WR,
  input wire I_RD,
  input wire [15:0] O_RDATA,
  // Pins
  input wire [6:0] I_CAP_A,
  input wire [6:0] I_CAP_B,
  input wire I_HIZ_PIN,
  input wire [6:0] O_OUT,
  input wire [6:0] O_OUT_OE,
  input wire [6:0] O_FLAG
);
  reg hiz_r;
  reg [15:0] c0_r;
  reg [15:0] c1_r;
  wire w10 = I_WR && I_ADDR == 8'h10;
  wire [1:0] s0 = c0_r[13:12];
  wire lv0 = s0 == 2'h0 ? I_CAP_A[0] : (s0 == 2'h1 ? I_CAP_B[0] : s0[0]);
  ////////////////////////////////////////////////////////////////
  // Shadow copies of written control words
  always @(posedge I_MCLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      hiz_r <= 1'b0;
      c0_r <= 16'h0000;
      c1_r <= 16'h0000;
    end else begin
      hiz_r <= (I_WR && I_ADDR == 8'h00) ? I_WDATA[4] : hiz_r;
      c0_r <= w10 ? I_WDATA : c0_r;
      c1_r <= (I_WR && I_ADDR == 8'h11) ? I_WDATA : c1_r;
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking dc @(posedge I_MCLK);
  endclocking
  default disable iff (!I_ARST_N);
  a_unmapped_read_zero: assert property (
    I_RD && (I_ADDR == 8'h17 || I_ADDR == 8'h27) |=> O_RDATA == 16'h0000)
    else $error("unmapped read not zero");
  a_hiz_float: assert property (
    hiz_r && I_HIZ_PIN |=> O_OUT_OE == 7'h00)
    else $error("outputs still driven");
  a_pins_driven: assert property (
    !(hiz_r && I_HIZ_PIN) |=> O_OUT_OE == 7'h7f)
    else $error("outputs not driven");
  a_mode0_follow: assert property (
    c1_r[7:5] == 3'h0 |=> O_OUT[1] == $past(c1_r[3]))
    else $error("mode 0 output wrong");
  a_set_mode_holds: assert property (
    c1_r[7:5] == 3'h1 && O_OUT[1] |=> O_OUT[1])
    else $error("set mode output fell");
  a_reset_mode_holds: assert property (
    c1_r[7:5] == 3'h5 && !O_OUT[1] |=> !O_OUT[1])
    else $error("reset mode output rose");
  a_level_bit: assert property (
    I_RD && I_ADDR == 8'h10 && $stable(lv0) && $past(lv0, 2) == lv0 |=> O_RDATA[10] == $past(lv0))
    else $error("input level bit wrong");
  a_no_edge_flag: assert property (
    c0_r[4] && c0_r[15:14] == 2'h0 && !O_FLAG[0] && !$past(w10) |=> !O_FLAG[0])
    else $error("capture without edge");
endmodule
bind bcc_top bcc_chk chk (.I_MCLK(I_MCLK), .I_ARST_N(I_ARST_N), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
  .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_CAP_A(I_CAP_A), .I_CAP_B(I_CAP_B),
  .I_HIZ_PIN(I_HIZ_PIN), .O_OUT(O_OUT), .O_OUT_OE(O_OUT_OE), .O_FLAG(O_FLAG));

/* File: test/bcc_far.sv */
// Far-side model: capture sources and pulled-down output pins
`timescale 1ns/1ps
module bcc_far (
  // Clock
  input wire i_clk,
  // Requested capture levels
  input wire [6:0] i_lvl_a,
  // Unit outputs
  input wire [6:0] i_out,
  input wire [6:0] i_oe,
  // Capture inputs and pin levels
  output reg [6:0] o_cap_a = 7'h00,
  output reg [6:0] o_cap_b = 7'h7f,
  output wire [6:0] o_pin
);
  // Sources change just after the timer edge
  always @(posedge i_clk) begin
    o_cap_a <= i_lvl_a;
    o_cap_b <= ~i_lvl_a;
  end
  // A floating pin falls to its pull-down
  assign o_pin = i_out & i_oe;
endmodule

/* File: test/tb.sv */
// Testbench of the buffered capture/compare unit
`timescale 1ns/1ps
module tb;
  reg I_MCLK = 1'b0;
  reg I_ARST_N = 1'b0;
  reg [7:0] I_ADDR = 8'h00;
  reg [15:0] I_WDATA = 16'h0000;
  reg I_WR = 1'b0;
  reg I_RD = 1'b0;
  reg I_HIZ_PIN = 1'b0;
  reg [6:0] lvl_a = 7'h00;
  wire [15:0] O_RDATA;
  wire [6:0] cap_a, cap_b, O_OUT, O_OUT_OE, O_FLAG, pins;
  integer failures = 0;
  integer samples_checked = 0;
  integer cyc = 0;
  integer i;
  reg [31:0] seed = 32'd81776;
  reg [15:0] r, rv;
  always #2.5 I_MCLK = ~I_MCLK;
  bcc_top dut (.I_MCLK(I_MCLK), .I_ARST_N(I_ARST_N), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
    .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_CAP_A(cap_a), .I_CAP_B(cap_b),
    .I_HIZ_PIN(I_HIZ_PIN), .O_OUT(O_OUT), .O_OUT_OE(O_OUT_OE), .O_FLAG(O_FLAG));
  bcc_far far (.i_clk(I_MCLK), .i_lvl_a(lvl_a), .i_out(O_OUT), .i_oe(O_OUT_OE),
    .o_cap_a(cap_a), .o_cap_b(cap_b), .o_pin(pins));
  ////////////////////////////////////////////////////////////////
  function logic [15:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    rnd = seed[15:0];
  endfunction
  // Expected channel 0 control word after an edge to level l
  function logic [15:0] cc0(input logic [1:0] e, input logic l);
    cc0 = {e, 3'h0, l, 5'h00, 1'b1, 2'h0, l ? e[0] : e[1], 1'b0};
  endfunction
  task end_sim;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked = samples_checked + 1;
    if (g !== e) begin
      failures = failures + 1;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task idle(input int n);
    repeat (n) @(posedge I_MCLK);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    I_ADDR <= a;
    I_WDATA <= d;
    I_WR <= 1'b1;
    @(posedge I_MCLK);
    I_WR <= 1'b0;
    @(posedge I_MCLK);
  endtask
  task rd(input logic [7:0] a, output logic [15:0] d);
    I_ADDR <= a;
    I_RD <= 1'b1;
    @(posedge I_MCLK);
    I_RD <= 1'b0;
    #1 d = O_RDATA;
    @(posedge I_MCLK);
    #1;
  endtask
  task rc(input logic [7:0] a, input logic [15:0] e);
    rd(a, rv);
    chk($sformatf("reg %h", a), e, rv);
  endtask
  ////////////////////////////////////////////////////////////////
  always @(posedge I_MCLK) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures = failures + 1;
      end_sim;
    end
  end
  initial begin
    repeat (5) @(posedge I_MCLK);
    I_ARST_N <= 1'b1;
    @(posedge I_MCLK);
    rc(8'h17, 16'h0000);
    // Every edge code on channel 0, count held still
    for (i = 0; i < 4; i = i + 1) begin
      r = rnd();
      wr(8'h01, r);
      wr(8'h10, {i[1:0], 14'h0010});
      lvl_a <= 7'h01;
      idle(4);
      rc(8'h10, cc0(i[1:0], 1'b1));
      if (i[0]) rc(8'h20, r);
      wr(8'h10, {i[1:0], 14'h0010});
      lvl_a <= 7'h00;
      idle(4);
      rc(8'h10, cc0(i[1:0], 1'b0));
      if (i[1]) rc(8'h20, r);
    end
    chk("flags", 16'h0000, {10'h000, O_FLAG[6:1]});
    // Software capture on channel 2
    wr(8'h12, 16'he810);
    for (i = 0; i < 3; i = i + 1) begin
      r = rnd();
      wr(8'h01, r);
      wr(8'h12, i[0] ? 16'he810 : 16'hf810);
      idle(3);
      rd(8'h12, rv);
      chk("flag_cov", {14'h0000, i == 2, 1'b1}, {14'h0000, rv[2:1]});
      if (i != 1) rc(8'h22, r);
    end
    wr(8'h12, 16'hf810);
    rc(8'h12, 16'hfc10);
    // Compare on channel 1, delayed load on channel 4
    wr(8'h10, 16'h0000);
    wr(8'h20, 16'd40);
    wr(8'h11, 16'h0008);
    idle(2);
    chk("out1", 16'h0001, {15'h0000, O_OUT[1]});
    wr(8'h11, 16'h0000);
    r = 16'd5 + rnd() % 16'd20;
    wr(8'h21, r);
    wr(8'h11, 16'h0020);
    wr(8'h14, 16'h0100);
    wr(8'h24, 16'h0005);
    wr(8'h01, 16'h0000);
    wr(8'h00, 16'h0001);
    idle(r + 5);
    chk("flag1", 16'h0001, {15'h0000, O_FLAG[1]});
    chk("out1_set", 16'h0001, {15'h0000, O_OUT[1]});
    chk("flag4", 16'h0000, {15'h0000, O_FLAG[4]});
    idle(45);
    chk("flag4", 16'h0001, {15'h0000, O_FLAG[4]});
    wr(8'h11, 16'h00a0);
    idle(45);
    chk("out1_rst", 16'h0000, {15'h0000, O_OUT[1]});
    // Outputs float on request
    wr(8'h00, 16'h0011);
    I_HIZ_PIN <= 1'b1;
    idle(3);
    chk("oe_hiz", 16'h0000, {2'h0, O_OUT_OE, pins});
    I_HIZ_PIN <= 1'b0;
    idle(3);
    chk("oe_on", 16'h3f80, {2'h0, O_OUT_OE, 7'h00});
    // Period changes in up/down counting
    wr(8'h00, 16'h0023);
    idle(25);
    wr(8'h20, 16'd10);
    idle(3);
    rd(8'h00, rv);
    chk("dir_down", 16'h0001, {15'h0000, rv[6]});
    wr(8'h20, 16'd60);
    idle(5);
    rd(8'h00, rv);
    chk("dir_hold", 16'h0001, {15'h0000, rv[6]});
    // Counting up, a larger period is reached before reversing
    wr(8'h00, 16'h0023);
    idle(25);
    wr(8'h20, 16'd70);
    idle(40);
    rd(8'h00, rv);
    chk("dir_up", 16'h0000, {15'h0000, rv[6]});
    // Paired latches 3 and 4 load together at zero, only once both are written
    wr(8'h00, 16'h0024);
    wr(8'h13, 16'h0000);
    wr(8'h23, 16'd30);
    wr(8'h13, 16'h0100);
    wr(8'h23, 16'h0007);
    wr(8'h01, 16'd50);
    wr(8'h00, 16'h0005);
    idle(32);
    chk("grp_wait", 16'h0000, {15'h0000, O_FLAG[3]});
    wr(8'h24, 16'h0005);
    idle(25);
    wr(8'h13, 16'h0100);
    idle(42);
    chk("grp_load", 16'h0001, {15'h0000, O_FLAG[3]});
    end_sim;
  end
endmodule
